// ===== logic/lane_map_defines.svh
`ifndef LANE_MAP_DEFINES_SVH
`define LANE_MAP_DEFINES_SVH
// field positions within the byte address
`define LM_ADDR_W      28
`define LM_LANE_W      16
`define LM_PIN_W       28
`define LM_CS_W        8
`define LM_MUX_LO      1
`define LM_MUX_HI      17
`define LM_NM_HI       16
`define LM_HI_PINS     10
`define LM_UNUSED_LO   11
`define LM_TOP_BIT     27
// reset values
`define LM_CS_IDLE     8'hff
`define LM_PINS_IDLE   28'h0000000
`define LM_LANES_IDLE  16'h0000
`endif

// ===== logic/lane_map_pkg.sv
package lane_map_pkg;
  typedef enum logic [1:0] {
    ph_idle,
    ph_addr,
    ph_data
  } phase_t;
endpackage

// ===== logic/ext_mem_addr_data_lane_map.sv
`timescale 1ns/10ps
`include "lane_map_defines.svh"

// Functional notes
// - In non-multiplexed mode the sixteen shared lanes carry data bit n only.
// - Multiplexed: lane n carries address bit n+1 in the address phase.
// - Non-multiplexed: address pins 1 to 15 carry address bits 1 to 15.
// - In multiplexed mode address pin k (1..10) carries address bit k+16.
// - In multiplexed mode address pins 11 to 15 are unused.
// - Address pin 0 carries the byte address only for 8-bit non-mux parts.
// - Pins 16 to 26 carry their bits only when non-muxed; pin 27 always.
// - An active-low address-valid strobe doubles as an address latch enable.
// - Eight active-low chip selects, 0 to 7, each select one region.
module ext_mem_addr_data_lane_map #(
  parameter int ADDR_W = `LM_ADDR_W,
  parameter int LANE_W = `LM_LANE_W,
  parameter int CS_W   = `LM_CS_W
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              req,
  input  wire logic              addr_phase_done,
  input  wire logic              access_done,
  input  wire logic              muxed_mode,
  input  wire logic              byte_wide,
  input  wire logic              write_dir,
  input  wire logic [2:0]        cs_sel,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [LANE_W-1:0] wr_data,
  input  wire logic [LANE_W-1:0] lane_in,
  output logic      [LANE_W-1:0] lane_out,
  output logic      [LANE_W-1:0] lane_oe,
  output logic      [ADDR_W-1:0] addr_pin,
  output logic      [CS_W-1:0]   cs_n,
  output logic                   adv_n,
  output logic      [LANE_W-1:0] rd_data
);

  lane_map_pkg::phase_t phase;
  lane_map_pkg::phase_t next_phase;
  logic [LANE_W-1:0] next_lane_out;
  logic [LANE_W-1:0] next_lane_oe;
  logic [ADDR_W-1:0] next_addr_pin;
  logic [CS_W-1:0]   next_cs_n;
  logic              next_adv_n;
  logic [LANE_W-1:0] next_rd_data;

  // dedicated address pins for a given mode
  function automatic logic [ADDR_W-1:0] map_pins(
    input logic              mux,
    input logic              bw,
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] p;
    p = '0;
    if (mux) begin
      // upper bits fold onto the low pins
      p[`LM_HI_PINS:1] = a[`LM_HI_PINS+`LM_NM_HI:`LM_MUX_HI];
      // pins 11..26 stay low: nothing listens there while muxed
      p[`LM_TOP_BIT] = a[`LM_TOP_BIT];
    end else begin
      p[`LM_TOP_BIT:1] = a[`LM_TOP_BIT:1];
      p[0] = bw ? a[0] : 1'b0;
    end
    return p;
  endfunction

  // next-state and pin values
  always_comb begin
    next_phase    = phase;
    next_lane_out = lane_out;
    next_lane_oe  = lane_oe;
    next_addr_pin = addr_pin;
    next_cs_n     = cs_n;
    next_adv_n    = adv_n;
    next_rd_data  = rd_data;
    case (phase)
      lane_map_pkg::ph_idle: begin
        if (req) begin
          next_addr_pin = map_pins(muxed_mode, byte_wide, addr);
          next_cs_n = `LM_CS_IDLE;
          next_cs_n[cs_sel] = 1'b0;
          if (muxed_mode) begin
            next_phase    = lane_map_pkg::ph_addr;
            next_lane_out = addr[`LM_MUX_LO+LANE_W-1:`LM_MUX_LO];
            next_lane_oe  = '1;
            next_adv_n    = 1'b0;
          end else begin
            next_phase    = lane_map_pkg::ph_data;
            next_lane_out = wr_data;
            next_lane_oe  = {LANE_W{write_dir}};
          end
        end
      end
      lane_map_pkg::ph_addr: begin
        if (addr_phase_done) begin
          // strobe rises with the lane turn: latch edge precedes data
          next_phase    = lane_map_pkg::ph_data;
          next_adv_n    = 1'b1;
          next_lane_out = wr_data;
          next_lane_oe  = {LANE_W{write_dir}};
        end
      end
      lane_map_pkg::ph_data: begin
        if (access_done) begin
          next_phase   = lane_map_pkg::ph_idle;
          next_cs_n    = `LM_CS_IDLE;
          next_lane_oe = '0;
          next_lane_out = `LM_LANES_IDLE;
          if (!write_dir) begin
            next_rd_data = lane_in;
          end
        end
      end
      default: begin
        next_phase = lane_map_pkg::ph_idle;
      end
    endcase
  end

  // registers only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase    <= lane_map_pkg::ph_idle;
      lane_out <= `LM_LANES_IDLE;
      lane_oe  <= '0;
      addr_pin <= `LM_PINS_IDLE;
      cs_n     <= `LM_CS_IDLE;
      adv_n    <= 1'b1;
      rd_data  <= `LM_LANES_IDLE;
    end else begin
      phase    <= next_phase;
      lane_out <= next_lane_out;
      lane_oe  <= next_lane_oe;
      addr_pin <= next_addr_pin;
      cs_n     <= next_cs_n;
      adv_n    <= next_adv_n;
      rd_data  <= next_rd_data;
    end
  end

  property p_nm_lanes_data;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_idle && req && !muxed_mode)
      |=> (lane_out == $past(wr_data)) && adv_n;
  endproperty
  a_nm_lanes_data: assert property (p_nm_lanes_data)
    else $error("lanes not carrying data in non-mux mode");

  property p_mux_lanes_addr;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_idle && req && muxed_mode)
      |=> (lane_out == $past(addr[16:1])) && lane_oe == '1;
  endproperty
  a_mux_lanes_addr: assert property (p_mux_lanes_addr)
    else $error("lanes lack address bits 1..16");

  property p_nm_pins;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_idle && req && !muxed_mode)
      |=> addr_pin[27:1] == $past(addr[27:1]);
  endproperty
  a_nm_pins: assert property (p_nm_pins)
    else $error("pins differ from address in non-mux mode");

  property p_mux_hi;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_idle && req && muxed_mode)
      |=> addr_pin[10:1] == $past(addr[26:17]);
  endproperty
  a_mux_hi: assert property (p_mux_hi)
    else $error("pins 1..10 not carrying bits 17..26");

  property p_mux_unused;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_idle && req && muxed_mode)
      |=> addr_pin[26:11] == '0 && addr_pin[0] == 1'b0;
  endproperty
  a_mux_unused: assert property (p_mux_unused)
    else $error("unused pins driven in mux mode");

  property p_byte_pin;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_idle && req)
      |=> addr_pin[0] == $past(addr[0] & byte_wide & !muxed_mode);
  endproperty
  a_byte_pin: assert property (p_byte_pin)
    else $error("byte address pin wrong");

  property p_top_bit;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_idle && req)
      |=> addr_pin[27] == $past(addr[27]);
  endproperty
  a_top_bit: assert property (p_top_bit)
    else $error("pin 27 not carrying bit 27");

  property p_adv_addr;
    @(posedge sys_clk) disable iff (!nrst)
    !adv_n |-> phase == lane_map_pkg::ph_addr && lane_oe == '1;
  endproperty
  a_adv_addr: assert property (p_adv_addr)
    else $error("address strobe outside address phase");

  property p_one_cs;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_idle && req)
      |=> $countones(~cs_n) == 1 && cs_n[$past(cs_sel)] == 1'b0;
  endproperty
  a_one_cs: assert property (p_one_cs)
    else $error("chip select decode wrong");

  property p_turn;
    @(posedge sys_clk) disable iff (!nrst)
    (phase == lane_map_pkg::ph_addr && addr_phase_done)
      |=> adv_n && lane_out == $past(wr_data)
          && lane_oe == {LANE_W{$past(write_dir)}};
  endproperty
  a_turn: assert property (p_turn)
    else $error("lanes not turned to data after strobe");

endmodule

// ===== tb/ext_mem_model.sv
`timescale 1ns/10ps
// far-side memory: latches the muxed word address while the strobe is low
module ext_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mux,
  input  wire logic [15:0] lane_out,
  input  wire logic [15:0] lane_oe,
  input  wire logic [27:0] addr_pin,
  input  wire logic [7:0]  cs_n,
  input  wire logic        adv_n,
  output logic      [15:0] lane_in
);
  logic [15:0] lat;
  // address must be held before the lanes turn to data
  always_ff @(posedge sys_clk) begin
    if (!adv_n) begin
      lat <= lane_out;
    end
  end
  // read data is the scrambled word address; a driven or deselected bus shows inverse
  always_comb begin
    if (cs_n != 8'hff && lane_oe == 16'h0000) begin
      lane_in = (mux ? lat : addr_pin[16:1]) ^ 16'h5a5a;
    end else begin
      lane_in = ~lane_out;
    end
  end
endmodule

// ===== tb/ext_mem_addr_data_lane_map_tb.sv
`timescale 1ns/10ps
module ext_mem_addr_data_lane_map_tb;
  logic        sys_clk, nrst, req, apd, ad, mux, bw, wr;
  logic [2:0]  cs_sel;
  logic [27:0] addr, addr_pin;
  logic [15:0] wr_data, lane_in, lane_out, lane_oe, rd_data;
  logic [7:0]  cs_n;
  logic        adv_n;
  int          error_cnt = 0;
  int          cmp_count = 0;

  ext_mem_addr_data_lane_map i_ext_mem_addr_data_lane_map (
    .sys_clk(sys_clk), .nrst(nrst), .req(req), .addr_phase_done(apd),
    .access_done(ad), .muxed_mode(mux), .byte_wide(bw), .write_dir(wr),
    .cs_sel(cs_sel), .addr(addr), .wr_data(wr_data), .lane_in(lane_in),
    .lane_out(lane_out), .lane_oe(lane_oe), .addr_pin(addr_pin),
    .cs_n(cs_n), .adv_n(adv_n), .rd_data(rd_data));
  ext_mem_model i_ext_mem_model (
    .sys_clk(sys_clk), .mux(mux), .lane_out(lane_out), .lane_oe(lane_oe),
    .addr_pin(addr_pin), .cs_n(cs_n), .adv_n(adv_n), .lane_in(lane_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [27:0] e,
                     input logic [27:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // one whole access; inputs change only at the falling edge
  task automatic acc(input logic m, input logic b, input logic w,
                     input logic [2:0] c, input logic [27:0] a,
                     input logic [15:0] d);
    logic [27:0] p;
    logic [7:0]  ce;
    p = 28'h0000000;
    ce = ~(8'h01 << c);
    p[27] = a[27];
    if (m) p[10:1] = a[26:17];
    else p[26:1] = a[26:1];
    if (!m && b) p[0] = a[0];
    @(negedge sys_clk);
    {req, mux, bw, wr, cs_sel, addr, wr_data} = {1'b1, m, b, w, c, a, d};
    @(negedge sys_clk);
    req = 1'b0;
    chk("addr_pin", p, addr_pin);
    chk("cs_n", 28'(ce), 28'(cs_n));
    chk("adv_n", 28'(!m), 28'(adv_n));
    chk("lane_oe", (m || w) ? 28'h000ffff : 28'h0, 28'(lane_oe));
    if (m || w) chk("lane_out", 28'(m ? a[16:1] : d), 28'(lane_out));
    if (m) begin
      apd = 1'b1;
      @(negedge sys_clk);
      apd = 1'b0;
      chk("adv_n", 28'h1, 28'(adv_n));
      chk("lane_oe", w ? 28'h000ffff : 28'h0, 28'(lane_oe));
      if (w) chk("lane_out", 28'(d), 28'(lane_out));
    end
    ad = 1'b1;
    @(negedge sys_clk);
    ad = 1'b0;
    chk("cs_n", 28'h00000ff, 28'(cs_n));
    chk("lane_oe", 28'h0, 28'(lane_oe));
    if (!w) chk("rd_data", 28'(a[16:1] ^ 16'h5a5a), 28'(rd_data));
  endtask

  task automatic t_nm_write();
    acc(1'b0, 1'b0, 1'b1, 3'h2, 28'h8abcdef, 16'h1234);
  endtask
  task automatic t_byte_read();
    acc(1'b0, 1'b1, 1'b0, 3'h5, 28'h0001235, 16'h0000);
  endtask
  task automatic t_mux_read();
    acc(1'b1, 1'b1, 1'b0, 3'h0, 28'hfedcba9, 16'h0000);
  endtask
  task automatic t_mux_write();
    acc(1'b1, 1'b0, 1'b1, 3'h7, 28'h7ffffff, 16'hbeef);
  endtask
  // every region, alternating modes, back to back
  task automatic t_cs_sweep();
    for (int i = 0; i < 8; i++) begin
      acc(i[0], 1'b0, i[1], 3'(i), 28'h5a5a5a5 + 28'(i), 16'(i));
    end
  endtask

  // a request or phase end outside its phase changes nothing
  task automatic t_refused();
    @(negedge sys_clk);
    req = 1'b1;
    mux = 1'b0;
    bw = 1'b0;
    wr = 1'b1;
    cs_sel = 3'h4;
    addr = 28'h0004444;
    wr_data = 16'h4444;
    @(negedge sys_clk);
    req = 1'b0;
    @(negedge sys_clk);
    // second request lands in the data phase and must be ignored
    req = 1'b1;
    apd = 1'b1;
    cs_sel = 3'h1;
    addr = 28'h0001110;
    wr_data = 16'h1111;
    @(negedge sys_clk);
    req = 1'b0;
    apd = 1'b0;
    chk("cs_n", 28'h00000ef, 28'(cs_n));
    chk("addr_pin", 28'h0004444, addr_pin);
    chk("lane_out", 28'h0004444, 28'(lane_out));
    chk("adv_n", 28'h1, 28'(adv_n));
    ad = 1'b1;
    @(negedge sys_clk);
    ad = 1'b0;
    chk("cs_n", 28'h00000ff, 28'(cs_n));
    chk("lane_oe", 28'h0, 28'(lane_oe));
  endtask

  // reset in mid-access drops every pin to idle; a new access runs after
  task automatic t_reset_mid();
    @(negedge sys_clk);
    req = 1'b1;
    mux = 1'b1;
    wr = 1'b1;
    cs_sel = 3'h3;
    addr = 28'h1234567;
    @(negedge sys_clk);
    req = 1'b0;
    chk("adv_n", 28'h0, 28'(adv_n));
    nrst = 1'b0;
    @(negedge sys_clk);
    chk("cs_n", 28'h00000ff, 28'(cs_n));
    chk("adv_n", 28'h1, 28'(adv_n));
    chk("lane_oe", 28'h0, 28'(lane_oe));
    chk("lane_out", 28'h0, 28'(lane_out));
    chk("addr_pin", 28'h0, addr_pin);
    chk("rd_data", 28'h0, 28'(rd_data));
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("cs_n", 28'h00000ff, 28'(cs_n));
    chk("adv_n", 28'h1, 28'(adv_n));
    acc(1'b0, 1'b0, 1'b1, 3'h1, 28'h0000abc, 16'h00cd);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // hang guard: the tests need well under a thousand cycles
  initial begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {nrst, req, apd, ad, mux, bw, wr, cs_sel} = 10'h000;
    addr = 28'h0000000;
    wr_data = 16'h0000;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    t_nm_write();
    t_byte_read();
    t_mux_read();
    t_mux_write();
    t_cs_sweep();
    t_refused();
    t_reset_mid();
    tally_and_finish();
  end
endmodule
